// File: design/sfc_top.sv
// Synthesizer channel frequency control with AHB-Lite register slave
//
// Contract
// - One 8-bit channel index register selects up to 256 channels, and writing it alone retunes; the code retunes only on a mode change.
// - Centre frequency is base plus index times spacing word times reference over 2^15.
// - Base is a 28-bit word times reference, over band/2 times ref divider, over 2^20.
// - Band divider is 4 when band select is 0 and 8 when it is 1.
// - Reference divider is 1 when its enable bit is 0 and 2 when it is 1.
// - For doubled references (48 to 52 MHz) the digital logic runs at half rate.
// - Unless disabled, calibration runs on every lock from ready and on each rx/tx swap.
// - A finished calibration stores its word in the registers and the synthesizer uses it.
//
// The AHB-Lite register port and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
`include "sfc_defs.svh"
module sfc_top #(
   parameter int CAL_W = 8
) (
   input  wire logic              hclk,
   input  wire logic              hresetn,
   input  wire logic              hsel,
   input  wire logic [31:0]       haddr,
   input  wire logic [1:0]        htrans,
   input  wire logic              hwrite,
   input  wire logic [2:0]        hsize,
   input  wire logic [31:0]       hwdata,
   input  wire logic              hready,
   output logic      [31:0]       hrdata,
   output logic                   hreadyout,
   output logic                   hresp,
   input  wire logic              cal_done,
   input  wire logic [CAL_W-1:0]  cal_result,
   output logic                   cal_start,
   output logic                   synth_enable,
   output logic      [31:0]       synth_freq_word,
   output logic      [CAL_W-1:0]  synth_cal_word,
   output logic                   band_select,
   output logic                   ref_div_enable,
   output logic      [2:0]        pump_current_sel,
   output logic                   phase_detector_split_en,
   output logic                   dig_clk_en
);
   logic [`SFC_BASE_W-1:0] base_freq_word_r;
   logic [7:0]             cfg_r;
   logic [7:0]             channel_spacing_word_r;
   logic [7:0]             channel_index_r;
   logic [1:0]             req_mode_r;
   logic [1:0]             cur_mode_r;
   logic [1:0]             tgt_mode_r;
   sfc_pkg::sfc_state_t    state_r;
   logic [31:0]            freq_calc_r;
   logic [7:0]             addr_r;
   logic                   rd_pend_r;
   logic                   wr_pend_r;
   logic                   dig_tog_r;
   logic                   cal_we;
   logic                   sw_cal_we;
   logic                   mem_we;
   logic                   mem_we_d_r;
   logic                   mem_waddr;
   logic [CAL_W-1:0]       mem_wdata;
   logic [CAL_W-1:0]       cal_run_word;
   logic [CAL_W-1:0]       cal_bus_word;
   logic                   accept;
   logic                   wr_now;
   logic                   step;
   logic                   need_cal;
   logic [15:0]            chan_prod;
   logic [1:0]             base_shl;
   logic [31:0]            rd_mux;

   assign accept = hsel && htrans[1] && hready;
   assign wr_now = wr_pend_r;
   assign step   = dig_clk_en;

   // Bus address and data phase tracking; reads take one wait state
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         addr_r    <= 8'h00;
         rd_pend_r <= 1'b0;
         wr_pend_r <= 1'b0;
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
      end else begin
         wr_pend_r <= accept && hwrite;
         if (accept) begin
            addr_r <= haddr[7:0];
         end
         if (accept && !hwrite) begin
            rd_pend_r <= 1'b1;
            hreadyout <= 1'b0;
         end else begin
            rd_pend_r <= 1'b0;
            hreadyout <= 1'b1;
         end
      end
   end

   always_comb begin
      rd_mux = 32'h00000000;
      case (addr_r)
         `SFC_OFF_BASE:   rd_mux = {4'h0, base_freq_word_r};
         `SFC_OFF_CFG:    rd_mux = {24'h000000, cfg_r};
         `SFC_OFF_SPACE:  rd_mux = {24'h000000, channel_spacing_word_r};
         `SFC_OFF_CHAN:   rd_mux = {24'h000000, channel_index_r};
         `SFC_OFF_MODE:   rd_mux = {30'h0, req_mode_r};
         `SFC_OFF_CAL_TX: rd_mux = 32'(cal_bus_word);
         `SFC_OFF_CAL_RX: rd_mux = 32'(cal_bus_word);
         `SFC_OFF_STATUS: rd_mux = {27'h0, state_r, cur_mode_r};
         `SFC_OFF_FREQ:   rd_mux = synth_freq_word;
         default:         rd_mux = 32'h00000000;
      endcase
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hrdata <= 32'h00000000;
      end else if (rd_pend_r) begin
         hrdata <= rd_mux;
      end
   end

   // Software-written configuration
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         base_freq_word_r       <= `SFC_BASE_RST;
         cfg_r                  <= `SFC_CFG_RST;
         channel_spacing_word_r <= `SFC_SPACE_RST;
         channel_index_r        <= `SFC_CHAN_RST;
         req_mode_r             <= sfc_pkg::SFC_MODE_READY;
      end else if (wr_now) begin
         case (addr_r)
            `SFC_OFF_BASE:  base_freq_word_r       <= hwdata[`SFC_BASE_W-1:0];
            `SFC_OFF_CFG:   cfg_r                  <= hwdata[7:0];
            `SFC_OFF_SPACE: channel_spacing_word_r <= hwdata[7:0];
            `SFC_OFF_CHAN:  channel_index_r        <= hwdata[7:0];
            `SFC_OFF_MODE:  req_mode_r             <= hwdata[1:0];
            default:        req_mode_r             <= req_mode_r;
         endcase
      end
   end

   // Static synthesizer controls follow the configuration register
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         band_select             <= 1'b0;
         ref_div_enable          <= 1'b0;
         pump_current_sel        <= 3'b000;
         phase_detector_split_en <= 1'b0;
      end else begin
         band_select             <= cfg_r[`SFC_CFG_BAND];
         ref_div_enable          <= cfg_r[`SFC_CFG_REF_DIV_ENABLE];
         pump_current_sel        <= cfg_r[`SFC_CFG_PUMP_HI:`SFC_CFG_PUMP_LO];
         phase_detector_split_en <= cfg_r[`SFC_CFG_SPLIT];
      end
   end

   // Digital rate enable, halved for doubled references
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         dig_tog_r  <= 1'b0;
         dig_clk_en <= 1'b0;
      end else begin
         dig_tog_r  <= ~dig_tog_r;
         dig_clk_en <= cfg_r[`SFC_CFG_XO_HALF] ? dig_tog_r : 1'b1;
      end
   end

   // Frequency word in units of reference/2^23; base divisor B/2*D is 2, 4 or 8
   assign chan_prod = 16'(channel_spacing_word_r) * 16'(channel_index_r);
   assign base_shl  = 2'(`SFC_BASE_SHIFT_MX) - 2'(cfg_r[`SFC_CFG_BAND])
                      - 2'(cfg_r[`SFC_CFG_REF_DIV_ENABLE]);

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         freq_calc_r <= 32'h00000000;
      end else begin
         freq_calc_r <= (32'(base_freq_word_r) << base_shl)
                        + (32'(chan_prod) << `SFC_CHAN_SHIFT);
      end
   end

   // Lock needed from ready, or on a swap between tx and rx
   assign need_cal = !cfg_r[`SFC_CFG_CAL_DIS]
                     && ((cur_mode_r == sfc_pkg::SFC_MODE_READY)
                         || (cur_mode_r == sfc_pkg::SFC_MODE_TX
                             && req_mode_r == sfc_pkg::SFC_MODE_RX)
                         || (cur_mode_r == sfc_pkg::SFC_MODE_RX
                             && req_mode_r == sfc_pkg::SFC_MODE_TX));

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         state_r         <= sfc_pkg::SFC_ST_IDLE;
         cur_mode_r      <= sfc_pkg::SFC_MODE_READY;
         tgt_mode_r      <= sfc_pkg::SFC_MODE_READY;
         cal_start       <= 1'b0;
         synth_enable    <= 1'b0;
         synth_freq_word <= 32'h00000000;
      end else begin
         cal_start <= 1'b0;
         if (step) begin
            case (state_r)
               sfc_pkg::SFC_ST_IDLE, sfc_pkg::SFC_ST_RUN: begin
                  if (req_mode_r == sfc_pkg::SFC_MODE_READY) begin
                     state_r      <= sfc_pkg::SFC_ST_IDLE;
                     cur_mode_r   <= sfc_pkg::SFC_MODE_READY;
                     synth_enable <= 1'b0;
                  end else if (req_mode_r != cur_mode_r) begin
                     synth_freq_word <= freq_calc_r;
                     synth_enable    <= 1'b1;
                     tgt_mode_r      <= req_mode_r;
                     if (need_cal) begin
                        state_r   <= sfc_pkg::SFC_ST_CAL;
                        cal_start <= 1'b1;
                     end else begin
                        state_r    <= sfc_pkg::SFC_ST_RUN;
                        cur_mode_r <= req_mode_r;
                     end
                  end
               end
               sfc_pkg::SFC_ST_CAL: begin
                  if (cal_done) begin
                     state_r    <= sfc_pkg::SFC_ST_RUN;
                     cur_mode_r <= tgt_mode_r;
                  end
               end
               default: state_r <= sfc_pkg::SFC_ST_IDLE;
            endcase
         end
      end
   end

   // Calibration result has priority; a software write in the same cycle is dropped
   assign cal_we    = step && (state_r == sfc_pkg::SFC_ST_CAL) && cal_done;
   assign sw_cal_we = wr_now && (addr_r == `SFC_OFF_CAL_TX || addr_r == `SFC_OFF_CAL_RX);
   assign mem_we    = cal_we || sw_cal_we;
   assign mem_waddr = cal_we ? (tgt_mode_r == sfc_pkg::SFC_MODE_RX)
                             : (addr_r == `SFC_OFF_CAL_RX);
   assign mem_wdata = cal_we ? cal_result : hwdata[CAL_W-1:0];

   sfc_cal_mem #(
      .WIDTH (CAL_W),
      .DEPTH (2)
   ) u_cal_mem (
      .clk     (hclk),
      .rst_n   (hresetn),
      .we      (mem_we),
      .waddr   (mem_waddr),
      .wdata   (mem_wdata),
      .raddr_a (cur_mode_r == sfc_pkg::SFC_MODE_RX),
      .rdata_a (cal_run_word),
      .raddr_b (haddr[7:0] == `SFC_OFF_CAL_RX),
      .rdata_b (cal_bus_word)
   );

   // The synthesizer takes the fresh result at once, else the stored word
   // A written word reaches the read port a cycle late, so the copy waits that cycle
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         synth_cal_word <= '0;
         mem_we_d_r     <= 1'b0;
      end else begin
         mem_we_d_r <= mem_we;
         if (cal_we) begin
            synth_cal_word <= cal_result;
         end else if (state_r == sfc_pkg::SFC_ST_RUN && !mem_we && !mem_we_d_r) begin
            synth_cal_word <= cal_run_word;
         end
      end
   end
endmodule
`default_nettype wire

// File: design/sfc_defs.svh
// Register offsets, field positions and reset values of the synthesizer channel control
`ifndef SFC_DEFS_SVH
`define SFC_DEFS_SVH
`define SFC_OFF_BASE      8'h00
`define SFC_OFF_CFG       8'h04
`define SFC_OFF_SPACE     8'h08
`define SFC_OFF_CHAN      8'h0C
`define SFC_OFF_MODE      8'h10
`define SFC_OFF_CAL_TX    8'h14
`define SFC_OFF_CAL_RX    8'h18
`define SFC_OFF_STATUS    8'h1C
`define SFC_OFF_FREQ      8'h20
`define SFC_CFG_BAND      0
`define SFC_CFG_REF_DIV_ENABLE    1
`define SFC_CFG_XO_HALF   2
`define SFC_CFG_CAL_DIS   3
`define SFC_CFG_PUMP_LO   4
`define SFC_CFG_PUMP_HI   6
`define SFC_CFG_SPLIT     7
`define SFC_BASE_RST      28'h0000000
`define SFC_CFG_RST       8'h00
`define SFC_SPACE_RST     8'h00
`define SFC_CHAN_RST      8'h00
`define SFC_CAL_RST       8'h00
`define SFC_BASE_W        28
`define SFC_CHAN_SHIFT    8
`define SFC_BASE_SHIFT_MX 2
`endif

// File: design/sfc_pkg.sv
// Types of the synthesizer channel control
`default_nettype none
package sfc_pkg;
   typedef enum logic [2:0] {
      SFC_ST_IDLE = 3'b001,
      SFC_ST_CAL  = 3'b010,
      SFC_ST_RUN  = 3'b100
   } sfc_state_t;
   typedef enum logic [1:0] {
      SFC_MODE_READY = 2'b00,
      SFC_MODE_LOCK  = 2'b01,
      SFC_MODE_TX    = 2'b10,
      SFC_MODE_RX    = 2'b11
   } sfc_mode_t;
endpackage
`default_nettype wire

// File: design/sfc_cal_mem.sv
// Calibration word store: one write port, two registered read ports
`timescale 1ns/1ps
`default_nettype none
module sfc_cal_mem #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 2,
   parameter int AW    = $clog2(DEPTH)
) (
   input  wire logic             clk,
   input  wire logic             rst_n,
   input  wire logic             we,
   input  wire logic [AW-1:0]    waddr,
   input  wire logic [WIDTH-1:0] wdata,
   input  wire logic [AW-1:0]    raddr_a,
   output logic      [WIDTH-1:0] rdata_a,
   input  wire logic [AW-1:0]    raddr_b,
   output logic      [WIDTH-1:0] rdata_b
);
   logic [WIDTH-1:0] mem [DEPTH];
   genvar g;
   generate
      for (g = 0; g < DEPTH; g++) begin : g_entry
         always_ff @(posedge clk or negedge rst_n) begin
            if (!rst_n) begin
               mem[g] <= '0;
            end else if (we && (waddr == AW'(g))) begin
               mem[g] <= wdata;
            end
         end
      end
   endgenerate
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rdata_a <= '0;
         rdata_b <= '0;
      end else begin
         rdata_a <= mem[raddr_a];
         rdata_b <= mem[raddr_b];
      end
   end
endmodule
`default_nettype wire

// File: bench/sfc_top_assertions.sv
// Port-level checker of the synthesizer channel control
`timescale 1ns/1ps
`default_nettype none
module sfc_checker #(
   parameter int CAL_W = 8
) (
   input wire logic             hclk,
   input wire logic             hresetn,
   input wire logic             hsel,
   input wire logic [31:0]      haddr,
   input wire logic [1:0]       htrans,
   input wire logic             hwrite,
   input wire logic [31:0]      hwdata,
   input wire logic             hready,
   input wire logic             hreadyout,
   input wire logic             hresp,
   input wire logic             cal_done,
   input wire logic [CAL_W-1:0] cal_result,
   input wire logic             cal_start,
   input wire logic             synth_enable,
   input wire logic [CAL_W-1:0] synth_cal_word,
   input wire logic             band_select,
   input wire logic             ref_div_enable,
   input wire logic [2:0]       pump_current_sel,
   input wire logic             phase_detector_split_en,
   input wire logic             dig_clk_en
);
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);
   wire logic  take = hsel && htrans[1] && hready;
   logic       cfg_dp_r;
   logic [7:0] cfg_val_r;
   // Data of the last config write, so copies can be compared across the data phase
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         cfg_dp_r  <= 1'b0;
         cfg_val_r <= 8'h00;
      end else begin
         cfg_dp_r <= take && hwrite && (haddr[7:0] == 8'h04);
         if (cfg_dp_r && hready) begin
            cfg_val_r <= hwdata[7:0];
         end
      end
   end
   sequence rd_take;
      take && !hwrite;
   endsequence
   sequence cal_seen;
      cal_start ##[1:60] cal_done;
   endsequence
   AST_HRESP_OKAY: assert property (hresp == 1'b0)
      else $error("error response seen");
   AST_READ_WAIT: assert property (rd_take |=> !hreadyout ##1 hreadyout)
      else $error("read wait state wrong");
   AST_WRITE_NOWAIT: assert property (take && hwrite |=> hreadyout)
      else $error("write stalled");
   AST_DIG_GAP: assert property (!dig_clk_en |=> dig_clk_en)
      else $error("digital enable low twice");
   AST_CAL_PULSE: assert property (cal_start |=> !cal_start)
      else $error("calibration start longer than one cycle");
   AST_CAL_LOCKS: assert property (cal_start |-> ##[0:2] synth_enable)
      else $error("calibration without synthesizer on");
   AST_CAL_WORD: assert property (cal_seen |=> (synth_cal_word == cal_result) [*3])
      else $error("calibration result not applied");
   AST_CFG_COPY: assert property (cfg_dp_r && hready |-> ##[1:3]
      ({phase_detector_split_en, pump_current_sel, ref_div_enable, band_select}
       == {cfg_val_r[7:4], cfg_val_r[1:0]}))
      else $error("config outputs do not follow write");
endmodule
`default_nettype wire

// File: bench/synth_channel_freq_control_test.sv
// Self-checking bench of the synthesizer channel frequency control
`timescale 1ns/1ps
`default_nettype none
`include "sfc_defs.svh"
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin failures++; \
   $display("unexpected at %0t: got %h want %h", $time, (a), (b)); end end
module synth_channel_freq_control_test;
   logic        hclk, hresetn, hsel, hwrite, cal_done, cal_start, synth_enable;
   logic        hreadyout, hresp, band_select, ref_div_enable, split_en, dig_clk_en;
   logic [31:0] haddr, hwdata, hrdata, freq, rd, base, st;
   logic [1:0]  htrans;
   logic [2:0]  hsize, pump;
   logic [7:0]  cal_result, cal_word, cfg, sp, idx, ctx;
   wire logic   hready = hreadyout;
   int          failures = 0, n_tests = 0, cyc = 0, cnt;
   logic [7:0]  offs [7] = '{`SFC_OFF_BASE, `SFC_OFF_CFG, `SFC_OFF_SPACE, `SFC_OFF_CHAN,
                             `SFC_OFF_CAL_TX, `SFC_OFF_FREQ, 8'h40};
   logic [1:0]  modes [5] = '{2'h3, 2'h2, 2'h3, 2'h0, 2'h1};
   sfc_top dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
      .hreadyout(hreadyout), .hresp(hresp), .cal_done(cal_done), .cal_result(cal_result),
      .cal_start(cal_start), .synth_enable(synth_enable), .synth_freq_word(freq),
      .synth_cal_word(cal_word), .band_select(band_select), .ref_div_enable(ref_div_enable),
      .pump_current_sel(pump), .phase_detector_split_en(split_en), .dig_clk_en(dig_clk_en));
   function automatic logic [31:0] xs();
      st = st ^ (st << 13);
      st = st ^ (st >> 17);
      st = st ^ (st << 5);
      return st;
   endfunction
   function automatic logic [31:0] exp_freq(logic [31:0] b, logic [7:0] c, s, i);
      logic [31:0] t;
      t = {24'h0, s};
      return (b << (2 - int'(c[0]) - int'(c[1]))) + ((t * {24'h0, i}) << 8);
   endfunction
   task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
      hsel <= 1'b1; htrans <= 2'b10; hwrite <= w; haddr <= {24'h0, a};
      @(posedge hclk);
      while (hready !== 1'b1) @(posedge hclk);
      hsel <= 1'b0; htrans <= 2'b00; hwdata <= d;
      @(posedge hclk);
      while (hready !== 1'b1) @(posedge hclk);
      rd = hrdata;
   endtask
   task automatic cal_run(input logic [7:0] r);
      cnt = 0;
      while (cal_start !== 1'b1 && cnt < 50) begin @(posedge hclk); cnt++; end
      `CHK(cal_start, 1'b1)
      cal_result <= r; cal_done <= 1'b1;
      repeat (2) @(posedge hclk);
      cal_done <= 1'b0;
      repeat (6) @(posedge hclk);
   endtask
   task automatic give_verdict;
      $display("comparisons %0d mismatches %0d", n_tests, failures);
      if (failures == 0 && n_tests > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   initial begin
      hclk = 1'b0;
      forever #2 hclk = ~hclk;
   end
   // Hang guard well above the few hundred cycles the sequence needs
   always @(posedge hclk) begin
      cyc++;
      if (cyc == 20000) begin failures++; give_verdict(); end
   end
   initial begin
      {hsel, hwrite, cal_done, hresetn} = 4'h0; haddr = 32'h0; htrans = 2'b00;
      hsize = 3'b010; hwdata = 32'h0; cal_result = 8'h00; st = 32'h1285;
      repeat (12) @(posedge hclk);
      hresetn <= 1'b1;
      ahb(1'b1, `SFC_OFF_STATUS, 32'hFF);
      ahb(1'b0, `SFC_OFF_STATUS, 32'h0); `CHK(rd, 32'h4)
      foreach (offs[i]) begin ahb(1'b0, offs[i], 32'h0); `CHK(rd, 32'h0) end
      $display("reset values done");
      for (int k = 0; k < 6; k++) begin
         base = xs() & 32'h0FFFFFFF; cfg = (8'(xs()) & 8'hF3) | 8'h08;
         sp = 8'(xs()); ctx = 8'(xs()); idx = (k == 0) ? 8'hFF : (k == 1) ? 8'h00 : 8'(xs());
         ahb(1'b1, `SFC_OFF_BASE, base); ahb(1'b1, `SFC_OFF_CFG, {24'h0, cfg});
         ahb(1'b1, `SFC_OFF_SPACE, {24'h0, sp}); ahb(1'b1, `SFC_OFF_CHAN, {24'h0, idx});
         ahb(1'b1, `SFC_OFF_CAL_TX, {24'h0, ctx}); ahb(1'b1, `SFC_OFF_MODE, 32'h1);
         repeat (10) @(posedge hclk);
         `CHK(freq, exp_freq(base, cfg, sp, idx))
         `CHK(cal_word, ctx)
         `CHK({split_en, pump}, cfg[7:4])
         `CHK({band_select, ref_div_enable}, {cfg[0], cfg[1]})
         ahb(1'b0, `SFC_OFF_STATUS, 32'h0); `CHK(rd, 32'h11)
         ahb(1'b0, `SFC_OFF_FREQ, 32'h0); `CHK(rd, exp_freq(base, cfg, sp, idx))
         ahb(1'b1, `SFC_OFF_MODE, 32'h0); ahb(1'b1, `SFC_OFF_CHAN, {24'h0, idx + 8'h1});
         ahb(1'b1, `SFC_OFF_MODE, 32'h1);
         repeat (10) @(posedge hclk);
         `CHK(freq, exp_freq(base, cfg, sp, idx + 8'h1))
         ahb(1'b1, `SFC_OFF_MODE, 32'h0);
      end
      $display("frequency setting done");
      ahb(1'b1, `SFC_OFF_CFG, 32'h0);
      foreach (modes[i]) begin
         ahb(1'b1, `SFC_OFF_MODE, {30'h0, modes[i]});
         if (modes[i] == 2'h0) begin
            repeat (10) @(posedge hclk);
            `CHK(synth_enable, 1'b0)
            continue;
         end
         ctx = 8'(xs());
         cal_run(ctx);
         `CHK(cal_word, ctx)
         ahb(1'b0, (modes[i] == 2'h3) ? `SFC_OFF_CAL_RX : `SFC_OFF_CAL_TX, 32'h0);
         `CHK(rd, {24'h0, ctx})
      end
      ahb(1'b1, `SFC_OFF_MODE, 32'h0);
      $display("calibration done");
      ahb(1'b1, `SFC_OFF_CFG, 32'h0C);
      repeat (4) @(posedge hclk);
      cnt = 0;
      repeat (20) begin @(posedge hclk); cnt += int'(dig_clk_en); end
      `CHK(cnt, 10)
      $display("digital rate done");
      give_verdict();
   end
endmodule
bind sfc_top sfc_checker #(.CAL_W(CAL_W)) chk (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
   .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready),
   .hreadyout(hreadyout), .hresp(hresp), .cal_done(cal_done), .cal_result(cal_result),
   .cal_start(cal_start), .synth_enable(synth_enable), .synth_cal_word(synth_cal_word),
   .band_select(band_select), .ref_div_enable(ref_div_enable),
   .pump_current_sel(pump_current_sel), .phase_detector_split_en(phase_detector_split_en),
   .dig_clk_en(dig_clk_en));
`default_nettype wire
